// File: design/dasr_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock; read data come from a register.
 */
`timescale 1ns/1ps
module dasr_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [WIDTH-1:0] od_r, od_nxt;
	logic ov_r, ov_nxt;
	logic push, pop, empty;

	always_comb begin
		empty = (wp_r == rp_r);
		in_ready = ~((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
		push = in_valid & in_ready;
		// Output register refills whenever it is empty or being taken
		pop = ~empty & (~ov_r | out_ready);
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		od_nxt = pop ? mem[rp_r[AW-1:0]] : od_r;
		ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			od_r <= '0;
			ov_r <= 1'b0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			od_r <= od_nxt;
			ov_r <= ov_nxt;
		end
	end

	assign out_data = od_r;
	assign out_valid = ov_r;

endmodule : dasr_fifo

// File: design/dasr_pkg.sv
/*
 * Package for the differential converter serial readout block.
 * Assumes one system clock at 20 MHz; frame pins arrive asynchronous.
 */
package dasr_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int DASR_NULL_BITS = 4;
	localparam int DASR_DATA_BITS = 12;
	localparam int DASR_FRAME_BITS = DASR_NULL_BITS + DASR_DATA_BITS;
	localparam int DASR_CODE_STEPS = 4096;
	localparam int DASR_FIFO_DEPTH = 16;
	localparam logic [4:0] DASR_FRAME_LAST = 5'h10;
	localparam logic [11:0] DASR_CODE_RST = 12'h000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int DASR_SYS_HZ = 20000000;
	localparam int DASR_SCLK_MIN_KHZ = 3200;
	localparam int DASR_SCLK_MAX_KHZ = 8000;
	localparam int DASR_RATE_MIN_KSPS = 200;
	localparam int DASR_RATE_MAX_KSPS = 500;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		DASR_POWER_DOWN = 2'b00,
		DASR_SHIFT = 2'b01,
		DASR_DONE = 2'b10
	} dasr_state_t;

	typedef struct packed {
		logic [11:0] code;
	} dasr_sample_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
	} dasr_pins_t;

endpackage : dasr_pkg

// File: design/dasr_top.sv
/*
 * Digital serial conversion and readout of a 12-bit differential converter.
 * Assumes the host drives select and serial clock asynchronously to clk_sys,
 * and an analog front end delivers two's-complement codes through a stream.
 */
// Contract
// - Select low means normal mode; select high means power-down.
// - Each falling edge of select starts a new conversion.
// - Frame is four null bits then twelve result bits, MSB first.
// - Output changes on serial clock falling edges, stable for the rising.
// - Host serial clock paces transfer and is the sole conversion timing; here convert_start is timed by clk_sys from the select fall.
// - Result is two's-complement; negative inputs give negative codes.
// - Result resolves twelve bits; one step is reference over 4096.
`timescale 1ns/1ps
module dasr_top
	import dasr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [11:0] code_data,
	input wire logic code_valid,
	output logic code_ready,
	output logic dout,
	output logic dout_oe,
	output logic power_down,
	output logic convert_start,
	output logic sample_take
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	dasr_pins_t meta_r, sync_r, prev_r;
	dasr_pins_t pins_in;

	always_comb begin
		pins_in.cs_n = cs_n;
		pins_in.sclk = sclk;
	end

	// Reset to idle pin levels so release gives no false edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '{cs_n: 1'b1, sclk: 1'b0};
			sync_r <= '{cs_n: 1'b1, sclk: 1'b0};
			prev_r <= '{cs_n: 1'b1, sclk: 1'b0};
		end else begin
			meta_r <= pins_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	logic cs_fall, cs_rise, sclk_fall;
	always_comb begin
		cs_fall = prev_r.cs_n & ~sync_r.cs_n;
		cs_rise = ~prev_r.cs_n & sync_r.cs_n;
		sclk_fall = prev_r.sclk & ~sync_r.sclk;
	end

	// ****************************************
	// Result buffer
	// ****************************************
	logic [11:0] fifo_data;
	logic fifo_valid, fifo_ready;
	logic [4:0] fill_r, fill_nxt;
	logic ready_r, ready_nxt;
	logic code_push, code_pop;

	dasr_fifo #(
		.WIDTH(DASR_DATA_BITS),
		.DEPTH(DASR_FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_data(code_data),
		.in_valid(code_push),
		.in_ready(),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);

	// ****************************************
	// Buffer fill
	// ****************************************
	// Counts the output register too, so code_ready can come from a flop
	// and still drop on the very edge that takes the last free place
	always_comb begin
		code_push = code_valid & ready_r;
		code_pop = fifo_ready & fifo_valid;
		fill_nxt = fill_r;
		if (code_push && !code_pop) begin
			fill_nxt = fill_r + 5'h01;
		end else if (code_pop && !code_push) begin
			fill_nxt = fill_r - 5'h01;
		end
		ready_nxt = (fill_nxt < 5'(DASR_FIFO_DEPTH));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fill_r <= 5'h00;
			ready_r <= 1'b1;
		end else begin
			fill_r <= fill_nxt;
			ready_r <= ready_nxt;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	// Bit position reached after one more serial clock fall
	function automatic logic [4:0] next_pos(input logic [4:0] pos);
		return pos + 5'h01;
	endfunction : next_pos

	// ****************************************
	// Frame sequencer
	// ****************************************
	dasr_state_t state_r, state_nxt;
	logic [4:0] bit_r, bit_nxt;
	dasr_sample_t shreg_r, shreg_nxt;
	logic dout_r, dout_nxt;
	logic oe_r, oe_nxt;
	logic pd_r, pd_nxt;
	logic start_r, start_nxt;
	logic take_r, take_nxt;

	always_comb begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		shreg_nxt = shreg_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		pd_nxt = sync_r.cs_n;
		start_nxt = 1'b0;
		take_nxt = 1'b0;
		// Sample is latched at frame start so a late code cannot tear a frame
		fifo_ready = cs_fall;
		if (cs_rise) begin
			// Abort anywhere; select high always wins
			state_nxt = DASR_POWER_DOWN;
			oe_nxt = 1'b0;
			dout_nxt = 1'b0;
		end else begin
			unique case (state_r)
				DASR_POWER_DOWN: begin
					if (cs_fall) begin
						state_nxt = DASR_SHIFT;
						bit_nxt = '0;
						// Empty buffer reads as a zero code, never stale data
						shreg_nxt.code = fifo_valid ? fifo_data : DASR_CODE_RST;
						take_nxt = fifo_valid;
						start_nxt = 1'b1;
						oe_nxt = 1'b1;
						dout_nxt = 1'b0;
					end
				end
				DASR_SHIFT: begin
					if (sclk_fall) begin
						bit_nxt = next_pos(bit_r);
						if (next_pos(bit_r) < 5'(DASR_NULL_BITS)) begin
							dout_nxt = 1'b0;
						end else if (next_pos(bit_r) < DASR_FRAME_LAST) begin
							dout_nxt = shreg_r.code[11];
							shreg_nxt.code = {shreg_r.code[10:0], 1'b0};
						end else begin
							state_nxt = DASR_DONE;
							dout_nxt = 1'b0;
						end
					end
				end
				DASR_DONE: begin
					// Extra clocks past the frame shift zeros until select rises
					dout_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= DASR_POWER_DOWN;
			bit_r <= 5'h00;
			shreg_r <= '0;
			dout_r <= 1'b0;
			oe_r <= 1'b0;
			pd_r <= 1'b1;
			start_r <= 1'b0;
			take_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			shreg_r <= shreg_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			pd_r <= pd_nxt;
			start_r <= start_nxt;
			take_r <= take_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign dout = dout_r;
	assign dout_oe = oe_r;
	assign power_down = pd_r;
	assign convert_start = start_r;
	assign sample_take = take_r;
	assign code_ready = ready_r;

endmodule : dasr_top

// File: tb/dasr_host.sv
/* Host serial controller model.
 * Assumes calls start on a clk_sys edge. */
`timescale 1ns/1ps
module dasr_host (
	output logic cs_n,
	output logic sclk,
	input wire logic dout
);
	// ****
	// Frame
	// ****
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end
	// Odd offset keeps sampling off clk_sys edges
	// Clock and frame rate sit below the rated range so clk_sys can sample them
	task automatic run_frame(input int gap, output logic [15:0] word);
		#(gap + 13);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#300 sclk = 1'b1;
			word[i] = dout;
			#100 sclk = 1'b0;
		end
		#100 cs_n = 1'b1;
	endtask : run_frame
endmodule : dasr_host

// File: tb/dasr_sva.sv
/* Checker for dasr_top pins.
 * Assumes host keeps select high between frames. */
`timescale 1ns/1ps
module dasr_sva (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic power_down,
	input wire logic convert_start,
	input wire logic sample_take
);
	// ****
	// Cycles since serial clock fall
	// ****
	logic sclk_q_r, sclk_q_nxt;
	logic [3:0] since_r, since_nxt;
	always_comb begin
		sclk_q_nxt = sclk;
		since_nxt = (since_r == 4'hF) ? since_r : since_r + 4'h1;
		if (sclk_q_r && !sclk) begin
			since_nxt = 4'h0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q_r <= 1'b0;
			since_r <= 4'hF;
		end else begin
			sclk_q_r <= sclk_q_nxt;
			since_r <= since_nxt;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence cs_idle_fall;
		cs_n[*6] ##1 !cs_n;
	endsequence
	AST_PD_ON: assert property (cs_n[*6] |-> power_down && !dout_oe)
		else $error("power-down not entered");
	AST_PD_OFF: assert property ((!cs_n)[*6] |-> !power_down)
		else $error("power-down while selected");
	AST_QUIET: assert property (power_down |-> !dout)
		else $error("data in power-down");
	AST_START: assert property (cs_idle_fall |-> ##[2:6] convert_start)
		else $error("no conversion start");
	AST_TAKE: assert property (sample_take |-> convert_start)
		else $error("sample without start");
	AST_ONCE: assert property (convert_start ##1 (!cs_n)[*8] |-> !convert_start)
		else $error("restart inside frame");
	AST_NULL: assert property (convert_start |-> (dout_oe && !dout) ##1 (!dout)[*7])
		else $error("null bits not zero");
	AST_EDGE: assert property ($changed(dout) && dout_oe && $past(dout_oe) |-> since_r inside {[2:6]})
		else $error("data moved off clock fall");
endmodule : dasr_sva
bind dasr_top dasr_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .dout(dout),
	.dout_oe(dout_oe), .power_down(power_down), .convert_start(convert_start), .sample_take(sample_take));

// File: tb/dasr_top_tb.sv
/* Self-checking bench for dasr_top.
 * Assumes the host model dasr_host. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("Error at %0t: %h vs %h", $time, a, b); end end
module dasr_top_tb;
	logic clk_sys, rst_n, cs_n, sclk, code_valid, code_ready, dout, dout_oe, power_down;
	logic [11:0] code_data, e;
	logic [15:0] word;
	logic [11:0] exp_q[$];
	logic [11:0] corner[4] = '{12'h800, 12'h7FF, 12'hFFF, 12'h001};
	int failures, checked, seed, i, n;
	dasr_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .code_data(code_data),
		.code_valid(code_valid), .code_ready(code_ready), .dout(dout), .dout_oe(dout_oe),
		.power_down(power_down), .convert_start(), .sample_take());
	dasr_host i_host (.cs_n(cs_n), .sclk(sclk), .dout(dout));
	// ****
	// Helpers
	// ****
	function automatic logic [15:0] exp_word(input logic [11:0] c);
		return {4'h0, c};
	endfunction : exp_word
	task automatic print_verdict();
		$display("Counts: %0d checked, %0d failures", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task automatic push(input logic [11:0] c);
		logic r;
		code_data <= c;
		code_valid <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys);
			r = code_ready;
			@(posedge clk_sys);
			n++;
		end while (r !== 1'b1 && n < 40);
		if (r !== 1'b1) begin
			failures++;
			print_verdict();
		end
		exp_q.push_back(c);
	endtask : push
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		#500000;
		failures++;
		print_verdict();
	end
	initial begin
		seed = 32'h83d4;
		rst_n = 1'b0;
		code_valid = 1'b0;
		code_data = 12'h000;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		for (i = 0; i < 16; i++)
			push(i < 4 ? corner[i] : 12'($random(seed)));
		code_data <= 12'hABC;
		repeat (3) begin
			@(negedge clk_sys);
			`CHK(code_ready, 1'b0)
		end
		@(posedge clk_sys);
		code_valid <= 1'b0;
		$display("Test fill done");
		// Last frame finds the buffer empty
		for (i = 0; i < 17; i++) begin
			@(posedge clk_sys);
			i_host.run_frame(50 * (($random(seed) & 7) + 8), word);
			e = exp_q.size() > 0 ? exp_q.pop_front() : 12'h000;
			`CHK(word, exp_word(e))
			repeat (6) @(negedge clk_sys);
			`CHK({power_down, dout_oe}, 2'b10)
		end
		$display("Test frames done");
		print_verdict();
	end
endmodule : dasr_top_tb
